// ===== hw/eeprom_pkg.sv
package eeprom_pkg;
  // reference clock
  localparam int          CLK_MHZ     = 50;     // ref_clk rate
  // erase/write timing, typical figures
  localparam real         T_BYTE_MS   = 10.0;   // byte mode, per byte
  localparam real         T_ERASE_MS  = 3.5;    // page mode erase
  localparam real         T_PROG_MS   = 28.0;   // page mode, all bytes
  localparam int          PAGE_BYTES  = 8;      // bytes per page write
  localparam int          BYTE_CYC    = int'(T_BYTE_MS * 1000.0 * CLK_MHZ);
  localparam int          ERASE_CYC   = int'(T_ERASE_MS * 1000.0 * CLK_MHZ);
  localparam int          PBYTE_CYC   = int'(T_PROG_MS * 1000.0 * CLK_MHZ) / PAGE_BYTES;
  // bit counter marks
  localparam logic [3:0]  CNT_BYTE    = 4'h8;   // eight bits shifted
  localparam logic [3:0]  CNT_ACK     = 4'h9;   // inside acknowledge slot
  localparam logic [3:0]  NB_FULL     = 4'h8;   // page limit in bytes
  // reset values
  localparam logic [7:0]  PTR_RST     = 8'h00;  // word pointer
  localparam logic [31:0] TIMER_RST   = 32'h0;  // program timer

  // link states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_READ, ST_SKIP
  } link_state_e;

  // one byte waiting to be programmed
  typedef struct packed {
    logic [10:0] addr;  // full memory address
    logic [7:0]  data;  // byte value
  } wr_word_s;
endpackage

// ===== hw/eeprom_slave.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// write staging buffer
module wr_fifo #(
  parameter int W     = 19,  // word width
  parameter int DEPTH = 16   // entries, power of two
) (
  input  wire logic         ref_clk,    // system clock
  input  wire logic         rst,        // async reset
  input  wire logic         ce,         // clock enable
  input  wire logic         flush,      // drop all entries
  input  wire logic         in_valid,   // push request
  output logic              in_ready,   // room available
  input  wire logic [W-1:0] in_data,    // pushed word
  output logic              out_valid,  // word available
  input  wire logic         out_ready,  // pop request
  output logic [W-1:0]      out_data    // head word
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("wr_fifo depth invalid");

  logic [W-1:0] mem_q [DEPTH];  // storage
  logic [AW:0]  wp_q;           // write pointer
  logic [AW:0]  rp_q;           // read pointer
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[AW-1:0]];

  // pointers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else if (ce)
    begin
      wp_q <= flush ? '0 : wp_q + (AW+1)'(push);
      rp_q <= flush ? '0 : rp_q + (AW+1)'(pop);
    end
  end

  // storage write
  always_ff @(posedge ref_clk)
  begin
    if (ce && push)
      mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule // wr_fifo

////////////////////////////////////////////////////////////////////////////////
// two-wire serial eeprom slave
module eeprom_slave #(
  parameter int          PAGE_BITS = 1,          // 0,1,2 page bits from select
  parameter int          FIFO_DEPTH = 16,        // staging depth
  parameter logic [3:0]  DEV_TYPE  = 4'h5,       // arbitrary value
  parameter int unsigned BYTE_CYCLES  = eeprom_pkg::BYTE_CYC,   // byte mode
  parameter int unsigned ERASE_CYCLES = eeprom_pkg::ERASE_CYC,  // page erase
  parameter int unsigned PBYTE_CYCLES = eeprom_pkg::PBYTE_CYC   // page byte
) (
  input  wire logic ref_clk,         // system clock
  input  wire logic rst,             // async reset
  input  wire logic ce,              // clock enable
  input  wire logic scl_in,          // serial clock pin
  input  wire logic sda_in,          // serial data pin level
  output logic      sda_out,         // data drive value, always low
  output logic      sda_oe,          // pull data low
  input  wire logic select_input_0,  // select pin 0
  input  wire logic select_input_1,  // select pin 1
  input  wire logic select_input_2,  // select pin 2
  input  wire logic wp,              // write protect pin
  output logic      write_busy       // programming in progress
);
  import eeprom_pkg::*;
  localparam int AW = 8 + PAGE_BITS;
  localparam logic [2:0] SEL_MASK = 3'(3'b111 << PAGE_BITS);
  localparam int FW = $bits(wr_word_s);
  initial if (PAGE_BITS > 2 || FIFO_DEPTH < PAGE_BYTES) $error("bad parameters");

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0]  in_m_q;   // first stage
  logic [5:0]  in_s_q;   // second stage
  logic [1:0]  prev_q;   // last scl, sda

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      in_m_q <= 6'h3F;
      in_s_q <= 6'h3F;
      prev_q <= 2'h3;
    end
    else if (ce)
    begin
      in_m_q <= {scl_in, sda_in, wp, select_input_2, select_input_1, select_input_0};
      in_s_q <= in_m_q;
      prev_q <= in_s_q[5:4];
    end
  end

  wire       scl_s  = in_s_q[5];
  wire       sda_s  = in_s_q[4];
  wire       wp_s   = in_s_q[3];
  wire [2:0] sel_s  = in_s_q[2:0];
  wire       rise   = ce & scl_s & ~prev_q[1];
  wire       fall   = ce & ~scl_s & prev_q[1];
  wire       start_ev = ce & scl_s & prev_q[1] & prev_q[0] & ~sda_s;
  wire       stop_ev  = ce & scl_s & prev_q[1] & ~prev_q[0] & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // protocol state
  link_state_e state_q;     // link state
  logic [3:0]  cnt_q;       // bit counter
  logic [7:0]  sh_q;        // received byte
  logic [7:0]  tx_q;        // byte being sent
  logic        oe_q;        // data pull-down
  logic        nack_q;      // master declined
  logic [7:0]  ptr_q;       // word pointer
  logic [2:0]  pg_q;        // page from address byte
  logic [3:0]  nb_q;        // data bytes this write
  logic        discard_q;   // write overflowed
  logic        busy_q;      // programming
  logic        erasing_q;   // erase phase
  logic        page_q;      // page mode timing
  logic [31:0] timer_q;     // phase timer
  logic [7:0]  mem_q [1 << AW];  // array
  logic        fi_ready;    // fifo room
  logic        fo_valid;    // fifo word
  wr_word_s    fo_word;     // fifo head

  // decode of the finished byte
  wire [10:0]  cur_addr = {pg_q, ptr_q};
  wire [7:0]   mem_byte = mem_q[cur_addr[AW-1:0]];
  wire         rx_done  = fall & (cnt_q == CNT_BYTE) & (state_q != ST_IDLE);
  wire         ack_end  = fall & (cnt_q == CNT_ACK) & (state_q != ST_IDLE);
  wire         dev_hit  = (sh_q[7:4] == DEV_TYPE) &
                          (((sh_q[3:1] ^ sel_s) & SEL_MASK) == 3'h0);
  wire         wr_prot  = wp_s & (PAGE_BITS > 0) & cur_addr[AW-1];
  wire         wr_ok    = (nb_q < NB_FULL) & ~wr_prot & fi_ready & ~discard_q;
  wire         push     = rx_done & (state_q == ST_WDATA) & wr_ok;
  wire         rd_go    = ack_end & (state_q == ST_READ) & ~nack_q;
  wire         commit   = stop_ev & (state_q == ST_WDATA) & (nb_q != 4'h0) &
                          ~discard_q & ~busy_q;
  wire         flush    = (start_ev | stop_ev) & ~busy_q & ~commit;
  wire         pop      = busy_q & ~erasing_q & (timer_q == TIMER_RST) & fo_valid;

  // acknowledge and next state for the byte just shifted
  logic        ack_now;
  link_state_e nxt_state;
  always_comb
  begin
    ack_now   = 1'b0;
    nxt_state = state_q;
    case (state_q)
      ST_DEV:
      begin
        ack_now   = dev_hit & ~busy_q;
        nxt_state = ~ack_now ? ST_SKIP : sh_q[0] ? ST_READ : ST_WADDR;
      end
      ST_WADDR:
      begin
        ack_now   = 1'b1;
        nxt_state = ST_WDATA;
      end
      ST_WDATA: ack_now = wr_ok;
      default:  ack_now = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit engine: sample on rise, drive on fall
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'hFF;
      oe_q    <= 1'b0;
      nack_q  <= 1'b0;
    end
    else if (start_ev)
    begin
      state_q <= ST_DEV;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
      nack_q  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      oe_q    <= 1'b0;
    end
    else if (state_q != ST_IDLE)
    begin
      if (rise && cnt_q < CNT_BYTE)
      begin
        sh_q  <= {sh_q[6:0], sda_s};
        tx_q  <= {tx_q[6:0], 1'b1};
        cnt_q <= cnt_q + 4'h1;
      end
      if (rise && cnt_q == CNT_ACK)
        nack_q <= sda_s;
      if (rx_done)
      begin
        cnt_q   <= CNT_ACK;
        oe_q    <= ack_now;
        state_q <= nxt_state;
      end
      if (ack_end)
      begin
        cnt_q <= 4'h0;
        oe_q  <= rd_go & ~mem_byte[7];
        tx_q  <= rd_go ? mem_byte : 8'hFF;
        if (state_q == ST_READ && nack_q)
          state_q <= ST_SKIP;
      end
      if (fall && cnt_q != 4'h0 && cnt_q < CNT_BYTE && state_q == ST_READ)
        oe_q <= ~tx_q[7];
    end
  end

  // word pointer, page and write byte count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr_q     <= PTR_RST;
      pg_q      <= 3'h0;
      nb_q      <= 4'h0;
      discard_q <= 1'b0;
    end
    else if (ce)
    begin
      if (start_ev)
        nb_q <= 4'h0;
      if (rx_done && state_q == ST_DEV && ack_now)
        pg_q <= sh_q[3:1] & ~SEL_MASK;
      if (rx_done && state_q == ST_WADDR)
      begin
        ptr_q     <= sh_q;
        discard_q <= 1'b0;
      end
      if (push)
      begin
        ptr_q[2:0] <= ptr_q[2:0] + 3'h1;
        nb_q       <= nb_q + 4'h1;
      end
      if (rx_done && state_q == ST_WDATA && nb_q == NB_FULL)
        discard_q <= 1'b1;
      if (rd_go)
        ptr_q <= ptr_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // erase/write timing after stop
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q    <= 1'b0;
      erasing_q <= 1'b0;
      page_q    <= 1'b0;
      timer_q   <= TIMER_RST;
    end
    else if (ce)
    begin
      if (commit)
      begin
        busy_q    <= 1'b1;
        page_q    <= nb_q == NB_FULL;
        erasing_q <= nb_q == NB_FULL;
        timer_q   <= (nb_q == NB_FULL) ? 32'(ERASE_CYCLES - 1) : 32'(BYTE_CYCLES - 1);
      end
      else if (busy_q)
      begin
        if (!erasing_q && !fo_valid)
          busy_q <= 1'b0;
        else if (timer_q != TIMER_RST)
          timer_q <= timer_q - 32'h1;
        else if (erasing_q)
        begin
          erasing_q <= 1'b0;
          timer_q   <= 32'(PBYTE_CYCLES - 1);
        end
        else
          timer_q <= page_q ? 32'(PBYTE_CYCLES - 1) : 32'(BYTE_CYCLES - 1);
      end
    end
  end

  // memory array programming
  always_ff @(posedge ref_clk)
  begin
    if (ce && pop)
      mem_q[fo_word.addr[AW-1:0]] <= fo_word.data;
  end

  // write data staging
  wr_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (fi_ready),
    .in_data   ({cur_addr, sh_q}),
    .out_valid (fo_valid),
    .out_ready (pop),
    .out_data  (fo_word)
  );

  assign sda_out    = 1'b0;
  assign sda_oe     = oe_q;
  assign write_busy = busy_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  AST_START_OPENS: assert property (@(posedge ref_clk) disable iff (rst)
    start_ev |=> state_q == ST_DEV && cnt_q == 4'h0 && !oe_q)
    else $error("start did not open transfer");
  AST_STOP_CLOSES: assert property (@(posedge ref_clk) disable iff (rst)
    stop_ev |=> state_q == ST_IDLE && !oe_q)
    else $error("stop did not close transfer");
  AST_BUSY_NO_ACK: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && state_q == ST_DEV && busy_q) |=> !oe_q && state_q == ST_SKIP)
    else $error("acknowledged while busy");
  AST_TYPE_MISMATCH: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && state_q == ST_DEV && sh_q[7:4] != DEV_TYPE) |=> !oe_q)
    else $error("wrong type acknowledged");
  AST_WADDR_ACK: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && state_q == ST_WADDR) |=> oe_q && state_q == ST_WDATA)
    else $error("word address not acknowledged");
  AST_NINTH_NACK: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && state_q == ST_WDATA && nb_q == NB_FULL) |=> !oe_q && discard_q)
    else $error("ninth byte acknowledged");
  AST_WP_NACK: assert property (@(posedge ref_clk) disable iff (rst)
    (rx_done && state_q == ST_WDATA && wr_prot) |=> !oe_q)
    else $error("protected byte acknowledged");
  AST_PAGE_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    push |=> ptr_q[7:3] == $past(ptr_q[7:3]) && ptr_q[2:0] == $past(ptr_q[2:0]) + 3'h1)
    else $error("page pointer wrap wrong");
  AST_READ_INC: assert property (@(posedge ref_clk) disable iff (rst)
    rd_go |=> ptr_q == $past(ptr_q) + 8'h01 && pg_q == $past(pg_q))
    else $error("read pointer not advanced");
  AST_COMMIT_BUSY: assert property (@(posedge ref_clk) disable iff (rst)
    commit |=> busy_q && write_busy)
    else $error("programming did not start");
endmodule // eeprom_slave

// ===== verification/bus_master.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// two-wire bus master model, open drain on data, clock idles high
module bus_master #(
  parameter int HALF = 20  // ref_clk cycles per clock half period
) (
  input  wire logic ref_clk,  // bench clock
  output logic      scl,      // serial clock drive
  output logic      sda_low,  // pull data low
  input  wire logic sda       // resolved data wire
);
  // bus idle at time zero, both lines high
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // wait n falling edges of the bench clock
  task automatic hw(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_c();
    hw(HALF / 2);
    sda_low = 1'b0;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    sda_low = 1'b1;
    hw(HALF);
    scl = 1'b0;
  endtask
  // stop: data rises while clock high, clock then stands high
  task automatic stop_c();
    hw(HALF / 2);
    sda_low = 1'b1;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF);
    sda_low = 1'b0;
    hw(HALF);
  endtask
  // one bit: data set mid low phase, held over high phase, sampled mid high
  task automatic bit_c(input logic b, output logic r);
    hw(HALF / 2);
    sda_low = ~b;
    hw(HALF / 2);
    scl = 1'b1;
    hw(HALF / 2);
    r = sda;
    hw(HALF / 2);
    scl = 1'b0;
  endtask
  // byte out, most significant first, ninth clock reads acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], r);
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  // byte in; last byte left unacknowledged to end the read
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(last, r);
  endtask
endmodule // bus_master

// ===== verification/tb_top.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// bench for the serial eeprom slave
module tb_top;
  import eeprom_pkg::*;
  localparam logic [3:0] DEVT = 4'h9;  // type nibble, arbitrary value
  localparam int BYTE_C = 400;   // shortened byte mode time
  localparam int ERASE_C = 150;  // shortened page erase time
  localparam int PBYTE_C = 100;  // shortened page byte time
  logic ref_clk, rst, ce, wp, scl, m_low, sda_oe, sda_out, write_busy;
  logic [2:0] sel;                // select pins 2..0
  logic [7:0] rdat [0:15];        // bytes read back
  logic       busy_prev;          // busy one cycle ago
  int         busy_run;           // length of last busy period
  int fail_count, comparisons;
  wire sda = (sda_oe ? sda_out : 1'b1) & ~m_low;  // pulled-up wired and
  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // busy period length
  always @(posedge ref_clk)
  begin
    busy_prev <= write_busy;
    if (write_busy === 1'b1)
      busy_run <= (busy_prev === 1'b1) ? busy_run + 1 : 1;
  end
  // serial clock period of 160 ns: 4 ref_clk cycles per half
  bus_master #(.HALF(4)) bus_master_i (.ref_clk(ref_clk), .scl(scl), .sda_low(m_low), .sda(sda));
  eeprom_slave #(.PAGE_BITS(1), .FIFO_DEPTH(16), .DEV_TYPE(DEVT), .BYTE_CYCLES(BYTE_C),
    .ERASE_CYCLES(ERASE_C), .PBYTE_CYCLES(PBYTE_C)) eeprom_slave_i (.ref_clk(ref_clk),
    .rst(rst), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_input_0(sel[0]), .select_input_1(sel[1]), .select_input_2(sel[2]), .wp(wp),
    .write_busy(write_busy));
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [7:0] ab(input logic pg, input logic rw);
    return {DEVT, 2'b10, pg, rw};  // select pins 2..1 then page then direction
  endfunction
  // write transfer of n bytes d0, d0+1, ...; acks[0] address, [1] pointer
  task automatic wr_xfer(input logic pg, input logic [7:0] p, input logic [7:0] d0,
                         input int n, output logic [15:0] acks);
    acks = '0;
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(pg, 1'b0), acks[0]);
    bus_master_i.wr_byte(p, acks[1]);
    for (int i = 0; i < n; i++)
      bus_master_i.wr_byte(d0 + 8'(i), acks[2 + i]);
    bus_master_i.stop_c();
  endtask
  // random read of n bytes into rdat
  task automatic rd_seq(input logic pg, input logic [7:0] p, input int n);
    logic a0, a1, a2;
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(pg, 1'b0), a0);
    bus_master_i.wr_byte(p, a1);
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(pg, 1'b1), a2);
    chk("read_acks", 3'h7, {a0, a1, a2});
    for (int i = 0; i < n; i++)
      bus_master_i.rd_byte(i == n - 1, rdat[i]);
    bus_master_i.stop_c();
  endtask
  // bounded wait for the programming cycle to end
  task automatic wait_idle();
    int k;
    for (k = 0; k < 5000 && write_busy !== 1'b0; k++)
      @(negedge ref_clk);
    if (k == 5000)
    begin
      chk("busy_timeout", 1'b0, 1'b1);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_byte();
    logic [15:0] a;
    logic        x;
    wr_xfer(1'b0, 8'h10, 8'hA0, 3, a);
    chk("byte_acks", 16'h001F, a);
    chk("busy_after_stop", 1'b1, write_busy);
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(1'b0, 1'b1), x);
    chk("ack_while_busy", 1'b0, x);
    bus_master_i.stop_c();
    wait_idle();
    chk("byte_busy_len", 1'b1, busy_run >= 3 * BYTE_C && busy_run <= 3 * BYTE_C + 16);
    rd_seq(1'b0, 8'h10, 2);
    chk("rand_rd0", 8'hA0, rdat[0]);
    chk("rand_rd1", 8'hA1, rdat[1]);
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(1'b0, 1'b1), x);
    bus_master_i.rd_byte(1'b1, rdat[0]);
    bus_master_i.stop_c();
    chk("current_rd", 8'hA2, rdat[0]);
  endtask
  task automatic t_page();
    logic [15:0] a;
    wr_xfer(1'b0, 8'h0C, 8'hB0, 8, a);
    chk("page_acks", 16'h03FF, a);
    wait_idle();
    chk("page_busy_len", 1'b1, busy_run >= ERASE_C + 8 * PBYTE_C &&
        busy_run <= ERASE_C + 8 * PBYTE_C + 16);
    rd_seq(1'b0, 8'h08, 8);
    for (int i = 0; i < 8; i++)
      chk("page_wrap", 8'hB0 + 8'((i + 4) % 8), rdat[i]);
  endtask
  task automatic t_over();
    logic [15:0] a;
    wr_xfer(1'b0, 8'h20, 8'hC0, 9, a);
    chk("ninth_nack", 16'h03FF, a);
    repeat (8) @(negedge ref_clk);
    chk("no_program", 1'b0, write_busy);
  endtask
  task automatic t_prot();
    logic [15:0] a;
    wp = 1'b1;
    wr_xfer(1'b1, 8'h05, 8'hD0, 1, a);
    chk("wp_acks", 16'h0003, a);
    wait_idle();
    wp = 1'b0;
    wr_xfer(1'b1, 8'hFF, 8'hE1, 1, a);
    chk("unprot_acks", 16'h0007, a);
    wait_idle();
    wr_xfer(1'b1, 8'h00, 8'hE2, 1, a);
    wait_idle();
    rd_seq(1'b1, 8'hFF, 2);
    chk("page1_ff", 8'hE1, rdat[0]);
    chk("wrap_511", 8'hE2, rdat[1]);
  endtask
  task automatic t_miss();
    logic x, y;
    bus_master_i.start_c();
    bus_master_i.wr_byte({4'h6, 2'b10, 2'b01}, x);
    bus_master_i.stop_c();
    bus_master_i.start_c();
    bus_master_i.wr_byte({DEVT, 2'b01, 2'b01}, y);
    bus_master_i.stop_c();
    chk("type_miss", 1'b0, x);
    chk("select_miss", 1'b0, y);
  endtask
  // staged bytes cut off by a repeated start are flushed; ce low freezes the timer
  task automatic t_abort();
    logic [15:0] a;
    a = '0;
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(1'b0, 1'b0), a[0]);
    bus_master_i.wr_byte(8'h40, a[1]);
    bus_master_i.wr_byte(8'h55, a[2]);
    bus_master_i.wr_byte(8'h66, a[3]);
    bus_master_i.start_c();
    bus_master_i.wr_byte(ab(1'b0, 1'b0), a[4]);
    bus_master_i.wr_byte(8'h48, a[5]);
    bus_master_i.stop_c();
    chk("abort_acks", 16'h003F, a);
    repeat (8) @(negedge ref_clk);
    chk("abort_no_program", 1'b0, write_busy);
    wr_xfer(1'b0, 8'h48, 8'h77, 1, a);
    chk("ce_acks", 16'h0007, a);
    repeat (8) @(negedge ref_clk);
    ce = 1'b0;
    repeat (100) @(negedge ref_clk);
    ce = 1'b1;
    wait_idle();
    chk("ce_freeze_len", 1'b1, busy_run >= BYTE_C + 100 && busy_run <= BYTE_C + 116);
    rd_seq(1'b0, 8'h48, 1);
    chk("abort_kept", 8'h77, rdat[0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    rst = 1'b1;
    wp = 1'b0;
    ce = 1'b1;
    sel = 3'b101;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("idle_busy", 1'b0, write_busy);
    chk("idle_sda_out", 1'b0, sda_out);
    chk("idle_sda_oe", 1'b0, sda_oe);
    t_byte();
    t_page();
    t_over();
    t_prot();
    t_miss();
    t_abort();
    final_report();
  end
endmodule // tb_top
